//--- core/rsw_defs.svh
`ifndef RSW_DEFS_SVH
`define RSW_DEFS_SVH

// register byte offsets
`define RSW_MODE_OFS        8'h00
`define RSW_WDC_OFS         8'h04
`define RSW_IRQ_STAT_OFS    8'h08
`define RSW_IRQ_MASK_OFS    8'h0C
`define RSW_SOFT_RST_OFS    8'h10
`define RSW_STATUS_OFS      8'h14

// field positions
`define RSW_SEL_LO_BIT      0
`define RSW_SEL_HI_BIT      1
`define RSW_WD_A_BIT        0
`define RSW_WD_B_BIT        1
`define RSW_IRQ_WOV_BIT     0
`define RSW_IRQ_CIC_BIT     1
`define RSW_ST_RSTOUT_BIT   0
`define RSW_ST_WDEN_BIT     1
`define RSW_ST_ARMED_BIT    2
`define RSW_ST_PORON_BIT    3
`define RSW_ST_UVD_BIT      4
`define RSW_ST_DEVRST_BIT   5
`define RSW_ST_WDCNT_LSB    16

// reset source selection codes
`define RSW_SEL_BASIC       2'h0
`define RSW_SEL_HIZ         2'h1
`define RSW_SEL_CI          2'h2
`define RSW_SEL_WD          2'h3

// reset values
`define RSW_MODE_RST        2'h0
`define RSW_MASK_RST        2'h0
`define RSW_SOFT_RST_VAL    8'h00
`define RSW_STAT_RST        2'h0

// command/indication codes forced while in reset
`define RSW_DEACT_REQ_CODE  4'h0
`define RSW_TIMING_REQ_CODE 4'h0

// bus answers
`define RSW_RESP_OKAY       2'h0
`define RSW_RESP_SLVERR     2'h2

// timing
`define RSW_CLK_PERIOD_NS   8
`define RSW_RST_PULSE_US    125
`define RSW_DEACT_US        10
`define RSW_WD_FRAMES       1024
`define RSW_RST_PULSE_CYC \
   ((`RSW_RST_PULSE_US * 1000 + `RSW_CLK_PERIOD_NS - 1) / `RSW_CLK_PERIOD_NS)
`define RSW_DEACT_CYC \
   ((`RSW_DEACT_US * 1000 + `RSW_CLK_PERIOD_NS - 1) / `RSW_CLK_PERIOD_NS)

`endif

//--- core/rsw_pkg.sv
package rsw_pkg;
   typedef logic [31:0] rsw_word_t;
   typedef logic [7:0]  rsw_addr_t;
   typedef logic [3:0]  rsw_ci_t;
   typedef logic [1:0]  rsw_sel_t;
   typedef logic [7:0]  rsw_blk_t;
endpackage

//--- core/rsw_reset_watchdog.sv
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "rsw_defs.svh"

module rsw_reset_watchdog #(
   parameter logic [15:0] PULSE_CYC = 16'(`RSW_RST_PULSE_CYC),
   parameter logic [15:0] DEACT_CYC = 16'(`RSW_DEACT_CYC)
) (
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire rsw_pkg::rsw_addr_t s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire rsw_pkg::rsw_word_t s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire rsw_pkg::rsw_addr_t s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output rsw_pkg::rsw_word_t      s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   input  wire logic               ext_reset_in_n,
   input  wire logic               supply_detect_en_n,
   input  wire logic               undervoltage_detect,
   input  wire logic               frame_sync,
   input  wire logic               tdm_clocks_active,
   input  wire rsw_pkg::rsw_ci_t   line_cmd_code_dn,
   output logic                    reset_out_n,
   output logic                    reset_out_oe,
   output logic                    device_reset,
   output rsw_pkg::rsw_blk_t       block_reset,
   output logic                    irq,
   output logic                    tdm_lines_high,
   output rsw_pkg::rsw_ci_t        ci_dn_reset_code,
   output rsw_pkg::rsw_ci_t        ci_up_reset_code,
   output logic                    tdm_clocks_keep
);
   import rsw_pkg::*;

   localparam logic [9:0] WD_LAST = 10'(`RSW_WD_FRAMES - 1);

   // pin synchronisers: ext reset, supply detect, uvd, frame sync, clk active
   logic [4:0] pin_meta_q;
   logic [4:0] pin_sync_q;
   logic       fs_prev_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta_q <= 5'h13;
         pin_sync_q <= 5'h13; // idle pin levels: no false frame edge
         fs_prev_q  <= 1'b0;
      end else begin
         pin_meta_q <= {tdm_clocks_active, frame_sync, undervoltage_detect,
                        supply_detect_en_n, ext_reset_in_n};
         pin_sync_q <= pin_meta_q;
         fs_prev_q  <= pin_sync_q[3];
      end
   end

   logic ext_rst_s, por_en_s, uvd_s;
   logic frame_rise, clocks_run_s, hw_cause;

   assign ext_rst_s    = ~pin_sync_q[0];
   assign por_en_s     = ~pin_sync_q[1];
   assign uvd_s        = pin_sync_q[2];
   assign frame_rise   = pin_sync_q[3] & ~fs_prev_q;
   assign clocks_run_s = pin_sync_q[4];
   // power-on/undervoltage is a source whatever the selection field says
   assign hw_cause     = ext_rst_s | (por_en_s & uvd_s);

   logic      aw_full_q, aw_full_d;
   rsw_addr_t awaddr_q, awaddr_d;
   logic      w_full_q, w_full_d;
   rsw_word_t wdata_q, wdata_d;
   logic      wlane_q, wlane_d;
   logic      bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic      rvalid_q, rvalid_d;
   rsw_word_t rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic      do_write, wr_hit, rd_hit;
   rsw_word_t rd_mux;

   assign s_axi_awready = ~aw_full_q & ~bvalid_q;
   assign s_axi_wready  = ~w_full_q & ~bvalid_q;
   assign s_axi_arready = ~rvalid_q;
   assign do_write      = aw_full_q & w_full_q & ~bvalid_q;

   function automatic logic addr_hit(input rsw_addr_t a);
      addr_hit = (a == `RSW_MODE_OFS) || (a == `RSW_WDC_OFS) ||
                 (a == `RSW_IRQ_STAT_OFS) || (a == `RSW_IRQ_MASK_OFS) ||
                 (a == `RSW_SOFT_RST_OFS) || (a == `RSW_STATUS_OFS);
   endfunction

   assign wr_hit = addr_hit(awaddr_q);
   assign rd_hit = addr_hit(s_axi_araddr);

   always_comb begin
      aw_full_d = aw_full_q;
      awaddr_d  = awaddr_q;
      w_full_d  = w_full_q;
      wdata_d   = wdata_q;
      wlane_d   = wlane_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_full_d = 1'b1;
         awaddr_d  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_full_d = 1'b1;
         wdata_d  = s_axi_wdata;
         wlane_d  = s_axi_wstrb[0];
      end
      if (do_write) begin
         aw_full_d = 1'b0;
         w_full_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = wr_hit ? `RSW_RESP_OKAY : `RSW_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rdata_d  = rd_hit ? rd_mux : 32'h0000_0000;
         rresp_d  = rd_hit ? `RSW_RESP_OKAY : `RSW_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         awaddr_q  <= 8'h00;
         w_full_q  <= 1'b0;
         wdata_q   <= 32'h0000_0000;
         wlane_q   <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `RSW_RESP_OKAY;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= `RSW_RESP_OKAY;
      end else begin
         aw_full_q <= aw_full_d;
         awaddr_q  <= awaddr_d;
         w_full_q  <= w_full_d;
         wdata_q   <= wdata_d;
         wlane_q   <= wlane_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;

   // only byte lane 0 carries fields
   logic we_mode, we_wdc, we_stat, we_mask, we_soft;
   assign we_mode = do_write & wlane_q & (awaddr_q == `RSW_MODE_OFS);
   assign we_wdc  = do_write & wlane_q & (awaddr_q == `RSW_WDC_OFS);
   assign we_stat = do_write & wlane_q & (awaddr_q == `RSW_IRQ_STAT_OFS);
   assign we_mask = do_write & wlane_q & (awaddr_q == `RSW_IRQ_MASK_OFS);
   assign we_soft = do_write & wlane_q & (awaddr_q == `RSW_SOFT_RST_OFS);

   rsw_sel_t  sel_q, sel_d;
   logic      wd_en_q, wd_en_d;
   logic      armed_q, armed_d;
   logic [9:0] wd_cnt_q, wd_cnt_d;
   logic [1:0] stat_q, stat_d;
   logic [1:0] mask_q, mask_d;
   rsw_blk_t  soft_q, soft_d;
   logic [1:0] wdc_q, wdc_d;
   rsw_ci_t   ci_prev_q;
   logic      ci_ok_q;
   logic [15:0] pulse_cnt_q, pulse_cnt_d;
   logic      wd_pulse_q, wd_pulse_d;
   logic [15:0] deact_cnt_q, deact_cnt_d;
   logic      ci_fire, wd_tick, wd_service, wd_fire, wd_select;
   logic      pulse_on, rst_req, rst_assert, dev_rst;

   assign ci_fire    = ci_ok_q & (line_cmd_code_dn != ci_prev_q) &
                       (sel_q == `RSW_SEL_CI);
   assign wd_select  = we_mode &&
                       (wdata_q[1:0] == `RSW_SEL_WD);
   assign wd_service = we_wdc & armed_q & ~wdata_q[`RSW_WD_A_BIT] &
                       wdata_q[`RSW_WD_B_BIT];
   // frame edges count only while the frame clocks run, so power-down freezes it
   assign wd_tick    = wd_en_q & frame_rise & clocks_run_s;
   assign wd_fire    = wd_tick & (wd_cnt_q == WD_LAST) &
                       ~wd_service & ~wd_select;
   assign pulse_on   = pulse_cnt_q != 16'h0000;
   assign rst_req    = hw_cause | pulse_on;
   assign rst_assert = rst_req | (deact_cnt_q != 16'h0000);
   assign dev_rst    = hw_cause | wd_pulse_q;

   always_comb begin
      sel_d    = sel_q;
      wd_en_d  = wd_en_q;
      armed_d  = armed_q;
      wd_cnt_d = wd_cnt_q;
      stat_d   = stat_q;
      mask_d   = mask_q;
      soft_d   = soft_q;
      wdc_d    = wdc_q;
      if (we_mode) begin
         sel_d = wdata_q[1:0];
      end
      if (we_mask) begin
         mask_d = wdata_q[1:0];
      end
      if (we_soft) begin
         soft_d = wdata_q[7:0];
      end
      if (we_wdc) begin
         wdc_d   = wdata_q[1:0];
         // any write other than the first step breaks the sequence
         armed_d = wdata_q[`RSW_WD_A_BIT] & ~wdata_q[`RSW_WD_B_BIT];
      end
      if (wd_select) begin
         wd_en_d  = 1'b1;
         wd_cnt_d = 10'h000;
      end else if (wd_service) begin
         wd_cnt_d = 10'h000;
      end else if (wd_tick) begin
         wd_cnt_d = wd_cnt_q + 10'h001;
      end
      // no write path clears the enable; only resets and a watchdog overflow do
      if (wd_fire || ci_fire) begin
         sel_d = `RSW_MODE_RST;
      end
      if (wd_fire) begin
         wd_en_d  = 1'b0;
         wd_cnt_d = 10'h000;
         armed_d  = 1'b0;
      end
      // set wins over a clear in the same cycle
      if (we_stat) begin
         stat_d = stat_q & ~wdata_q[1:0];
      end
      if (wd_fire) begin
         stat_d[`RSW_IRQ_WOV_BIT] = 1'b1;
      end
      if (ci_fire) begin
         stat_d[`RSW_IRQ_CIC_BIT] = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || hw_cause) begin
         sel_q    <= `RSW_MODE_RST;
         wd_en_q  <= 1'b0;
         armed_q  <= 1'b0;
         wd_cnt_q <= 10'h000;
         stat_q   <= `RSW_STAT_RST;
         mask_q   <= `RSW_MASK_RST;
         soft_q   <= `RSW_SOFT_RST_VAL;
         wdc_q    <= 2'h0;
      end else begin
         sel_q    <= sel_d;
         wd_en_q  <= wd_en_d;
         armed_q  <= armed_d;
         wd_cnt_q <= wd_cnt_d;
         stat_q   <= stat_d;
         mask_q   <= mask_d;
         soft_q   <= soft_d;
         wdc_q    <= wdc_d;
      end
   end

   always_comb begin
      pulse_cnt_d = pulse_cnt_q;
      wd_pulse_d  = wd_pulse_q;
      deact_cnt_d = deact_cnt_q;
      if (wd_fire || ci_fire) begin
         // shortest legal length; a new event restarts the pulse
         pulse_cnt_d = PULSE_CYC;
         wd_pulse_d  = wd_pulse_q | wd_fire;
      end else if (pulse_on) begin
         pulse_cnt_d = pulse_cnt_q - 16'h0001;
         if (pulse_cnt_q == 16'h0001) begin
            wd_pulse_d = 1'b0;
         end
      end
      if (rst_req) begin
         deact_cnt_d = por_en_s ? DEACT_CYC : 16'h0000;
      end else if (deact_cnt_q != 16'h0000) begin
         deact_cnt_d = deact_cnt_q - 16'h0001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pulse_cnt_q <= 16'h0000;
         wd_pulse_q  <= 1'b0;
         deact_cnt_q <= 16'h0000;
         ci_prev_q   <= `RSW_DEACT_REQ_CODE;
         ci_ok_q     <= 1'b0;
      end else begin
         pulse_cnt_q <= pulse_cnt_d;
         wd_pulse_q  <= wd_pulse_d;
         deact_cnt_q <= deact_cnt_d;
         ci_prev_q   <= line_cmd_code_dn;
         ci_ok_q     <= 1'b1;
      end
   end

   logic     rst_n_q, oe_q, dev_q, irq_q;
   rsw_blk_t blk_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rst_n_q <= 1'b0;
         oe_q    <= 1'b1;
         dev_q   <= 1'b1;
         blk_q   <= 8'hFF;
         irq_q   <= 1'b0;
      end else begin
         rst_n_q <= ~rst_assert;
         oe_q    <= sel_q != `RSW_SEL_HIZ;
         dev_q   <= dev_rst;
         blk_q   <= soft_q | {8{dev_rst}};
         irq_q   <= |(stat_d & ~mask_d);
      end
   end

   assign reset_out_n      = rst_n_q;
   assign reset_out_oe     = oe_q;
   assign device_reset     = dev_q;
   assign block_reset      = blk_q;
   assign irq              = irq_q;
   assign tdm_lines_high   = dev_q;
   assign ci_dn_reset_code = `RSW_DEACT_REQ_CODE;
   assign ci_up_reset_code = `RSW_TIMING_REQ_CODE;
   // clock generators sit outside every reset this block drives
   assign tdm_clocks_keep  = 1'b1;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (s_axi_araddr)
         `RSW_MODE_OFS:     rd_mux[1:0] = sel_q;
         `RSW_WDC_OFS:      rd_mux[1:0] = wdc_q;
         `RSW_IRQ_STAT_OFS: rd_mux[1:0] = stat_q;
         `RSW_IRQ_MASK_OFS: rd_mux[1:0] = mask_q;
         `RSW_SOFT_RST_OFS: rd_mux[7:0] = soft_q;
         `RSW_STATUS_OFS: begin
            rd_mux[`RSW_ST_RSTOUT_BIT] = rst_assert;
            rd_mux[`RSW_ST_WDEN_BIT]   = wd_en_q;
            rd_mux[`RSW_ST_ARMED_BIT]  = armed_q;
            rd_mux[`RSW_ST_PORON_BIT]  = por_en_s;
            rd_mux[`RSW_ST_UVD_BIT]    = uvd_s;
            rd_mux[`RSW_ST_DEVRST_BIT] = dev_rst;
            rd_mux[`RSW_ST_WDCNT_LSB +: 10] = wd_cnt_q;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

endmodule

//--- dv/rsw_chk_sva.sv
`timescale 1ns/1ns
module rsw_chk #(
   parameter logic [15:0] PULSE_CYC = 16'h0014
) (
   input wire logic               aclk,
   input wire logic               aresetn,
   input wire logic               ext_reset_in_n,
   input wire logic               supply_detect_en_n,
   input wire logic               undervoltage_detect,
   input wire logic               s_axi_rvalid,
   input wire logic               s_axi_rready,
   input wire rsw_pkg::rsw_word_t s_axi_rdata,
   input wire logic               reset_out_n,
   input wire logic               device_reset,
   input wire rsw_pkg::rsw_blk_t  block_reset,
   input wire logic               tdm_lines_high,
   input wire rsw_pkg::rsw_ci_t   ci_dn_reset_code,
   input wire rsw_pkg::rsw_ci_t   ci_up_reset_code,
   input wire logic               tdm_clocks_keep
);
   import rsw_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic        por_bad;
   logic [15:0] low_q;
   assign por_bad = !supply_detect_en_n && undervoltage_detect;
   // pin-driven resets last as long as the pin, so they are exempt
   always_ff @(posedge aclk) begin
      if (!aresetn || !ext_reset_in_n || por_bad) begin
         low_q <= 16'hFFFF;
      end else if (reset_out_n) begin
         low_q <= 16'h0000;
      end else if (low_q != 16'hFFFF) begin
         low_q <= low_q + 16'h0001;
      end
   end
   sequence s_ext_held;
      !ext_reset_in_n [*4];
   endsequence
   sequence s_por_held;
      por_bad [*4];
   endsequence
   sequence s_dev_held;
      device_reset [*3];
   endsequence
   chk_lines_high:
      assert property (tdm_lines_high == device_reset)
      else $error("data lines not forced high with reset");
   chk_dn_code:
      assert property (device_reset |-> ci_dn_reset_code == 4'h0)
      else $error("downstream code wrong in reset");
   chk_up_code:
      assert property (device_reset |-> ci_up_reset_code == 4'h0)
      else $error("upstream code wrong in reset");
   chk_clk_keep:
      assert property (tdm_clocks_keep)
      else $error("frame clocks gated");
   chk_ext_reset:
      assert property (s_ext_held |-> device_reset && !reset_out_n)
      else $error("external reset not applied");
   chk_blk_reset:
      assert property (s_dev_held |-> block_reset == 8'hFF)
      else $error("blocks not held in device reset");
   chk_por_reset:
      assert property (s_por_held |-> device_reset && !reset_out_n)
      else $error("undervoltage reset not applied");
   chk_pulse_min:
      assert property ($rose(reset_out_n) |-> low_q >= PULSE_CYC)
      else $error("reset pulse too short");
   chk_rdata_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=>
                       s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   chk_rd_close:
      assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer not closed");
endmodule

//--- dv/rsw_host.sv
`timescale 1ns/1ns
module rsw_host #(
   parameter int HOLD = 8
) (
   input wire logic aclk,
   input wire logic reset_out_n,
   input wire logic reset_out_oe,
   output int       pulses,
   output int       width,
   output logic     host_ok
);
   logic pin;
   int   low_cnt;
   int   quiet;
   // pulled up: an undriven pin reads as released
   assign pin = reset_out_oe ? reset_out_n : 1'b1;
   always @(posedge aclk) begin
      if (!pin) begin
         low_cnt <= low_cnt + 1;
      end else if (low_cnt != 0) begin
         pulses  <= pulses + 1;
         width   <= low_cnt;
         low_cnt <= 0;
      end
      quiet <= pin ? quiet + 1 : 0;
   end
   assign host_ok = quiet >= HOLD;
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ns
module testbench;
   import rsw_pkg::*;
   localparam logic [15:0] PULSE = 16'h0014;
   localparam logic [15:0] DEACT = 16'h0005;
   localparam logic [1:0]  OK    = 2'h0;
   localparam logic [1:0]  ERR   = 2'h2;
   logic       aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic       s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic       s_axi_arready, s_axi_rvalid, s_axi_rready, ext_reset_in_n;
   logic       supply_detect_en_n, undervoltage_detect, frame_sync, irq;
   logic       tdm_clocks_active, reset_out_n, reset_out_oe, device_reset;
   logic       tdm_lines_high, tdm_clocks_keep, host_ok, fs_run;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   rsw_addr_t  s_axi_awaddr, s_axi_araddr;
   rsw_word_t  s_axi_wdata, s_axi_rdata, rdat;
   rsw_ci_t    line_cmd_code_dn, ci_dn_reset_code, ci_up_reset_code;
   rsw_blk_t   block_reset;
   int         bad_count, checked, pulses, width, fs_n, n;
   rsw_reset_watchdog #(.PULSE_CYC(PULSE), .DEACT_CYC(DEACT)) uut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .ext_reset_in_n, .supply_detect_en_n,
      .undervoltage_detect, .frame_sync, .tdm_clocks_active,
      .line_cmd_code_dn, .reset_out_n, .reset_out_oe, .device_reset,
      .block_reset, .irq, .tdm_lines_high, .ci_dn_reset_code,
      .ci_up_reset_code, .tdm_clocks_keep);
   rsw_host u_host (.aclk, .reset_out_n, .reset_out_oe, .pulses, .width,
      .host_ok);
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // 4-cycle frames keep the 1024-frame period short
   always @(posedge aclk) begin
      fs_n       <= fs_n + 1;
      frame_sync <= fs_run & fs_n[1];
   end
   task automatic end_sim;
      $display("checked %0d, bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input rsw_word_t got, input rsw_word_t exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic fail_out;
      bad_count++;
      $display("unexpected at %0t: wait ran out", $time);
      end_sim;
   endtask
   task automatic wait_lvl(input logic v, input int lim, output int k);
      for (k = 0; k < lim; k++) begin
         @(negedge aclk);
         if (reset_out_n === v) return;
      end
      fail_out;
   endtask
   task automatic wait_ok;
      for (int k = 0; k < 200; k++) begin
         @(posedge aclk);
         if (host_ok === 1'b1) return;
      end
      fail_out;
   endtask
   task automatic wr(input rsw_addr_t a, input rsw_word_t d,
                     input logic [1:0] r);
      logic ta, tw, tb;
      logic [1:0] rb;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (int k = 0; k < 40; k++) begin
         @(negedge aclk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tb = s_axi_bvalid;
         rb = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb === 1'b1) begin
            s_axi_bready <= 1'b0;
            chk(rb, r);
            return;
         end
      end
      fail_out;
   endtask
   task automatic rd(input rsw_addr_t a, output rsw_word_t d,
                     output logic [1:0] r);
      logic ta, tb;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (int k = 0; k < 40; k++) begin
         @(negedge aclk);
         ta = s_axi_arvalid & s_axi_arready;
         tb = s_axi_rvalid;
         d  = s_axi_rdata;
         r  = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tb === 1'b1) begin
            s_axi_rready <= 1'b0;
            return;
         end
      end
      fail_out;
   endtask
   task automatic rdc(input rsw_addr_t a, input rsw_word_t e,
                      input logic [1:0] re);
      logic [1:0] r;
      rd(a, rdat, r);
      chk(rdat, e);
      chk(r, re);
   endtask
   task automatic t_regs;
      rdc(8'h00, 8'h00, OK);
      rdc(8'h0C, 8'h00, OK);
      rdc(8'h10, 8'h00, OK);
      rdc(8'h18, 8'h00, ERR);
      wr(8'h18, 8'hFF, ERR);
      s_axi_wstrb <= 4'hE;
      wr(8'h10, 8'hFF, OK);
      s_axi_wstrb <= 4'hF;
      rdc(8'h10, 8'h00, OK);
      chk({ci_dn_reset_code, ci_up_reset_code}, 8'h00);
   endtask
   task automatic t_sel;
      int p0;
      wr(8'h00, 8'h01, OK);
      repeat (3) @(negedge aclk);
      chk(reset_out_oe, 1'b0);
      rdc(8'h00, 8'h01, OK);
      p0 = pulses;
      @(posedge aclk) line_cmd_code_dn <= 4'h9;
      repeat (40) @(posedge aclk);
      wr(8'h00, 8'h00, OK);
      repeat (3) @(negedge aclk);
      chk({reset_out_oe, reset_out_n}, 2'h3);
      @(posedge aclk) line_cmd_code_dn <= 4'h3;
      repeat (40) @(posedge aclk);
      chk(pulses, p0);
      wr(8'h08, 8'h03, OK);
   endtask
   task automatic t_ci;
      wr(8'h00, 8'h02, OK);
      @(posedge aclk) line_cmd_code_dn <= 4'hC;
      wait_lvl(1'b0, 10, n);
      wait_lvl(1'b1, 600, n);
      repeat (2) @(negedge aclk);
      chk(width >= PULSE && width <= 2 * PULSE, 1'b1);
      rdc(8'h00, 8'h00, OK);
      rdc(8'h08, 8'h02, OK);
      chk(irq, 1'b1);
      wr(8'h0C, 8'h02, OK);
      repeat (2) @(negedge aclk);
      chk(irq, 1'b0);
      wr(8'h08, 8'h02, OK);
      rdc(8'h08, 8'h00, OK);
      wr(8'h0C, 8'h00, OK);
   endtask
   task automatic t_wd;
      int p0;
      logic [1:0] r;
      wr(8'h00, 8'h03, OK);
      fs_run <= 1'b1;
      p0 = pulses;
      repeat (3) begin
         repeat (2400) @(posedge aclk);
         wr(8'h04, 8'h01, OK);
         wr(8'h04, 8'h02, OK);
      end
      wr(8'h00, 8'h00, OK);
      tdm_clocks_active <= 1'b0;
      repeat (3000) @(posedge aclk);
      tdm_clocks_active <= 1'b1;
      repeat (4000) @(posedge aclk);
      chk(pulses, p0);
      wait_lvl(1'b0, 200, n);
      @(negedge aclk);
      chk(device_reset, 1'b1);
      wait_lvl(1'b1, 100, n);
      repeat (2) @(negedge aclk);
      chk(width >= PULSE && width <= PULSE + 2, 1'b1);
      rdc(8'h08, 8'h01, OK);
      rdc(8'h00, 8'h00, OK);
      rd(8'h14, rdat, r);
      chk(rdat[1], 1'b0);
      fs_run <= 1'b0;
      wr(8'h08, 8'h01, OK);
   endtask
   task automatic t_ext;
      wr(8'h10, 8'hA5, OK);
      repeat (3) @(negedge aclk);
      chk(block_reset, 8'hA5);
      wr(8'h0C, 8'h03, OK);
      @(posedge aclk) ext_reset_in_n <= 1'b0;
      repeat (30) @(negedge aclk);
      chk({device_reset, reset_out_n, block_reset}, 10'h2FF);
      chk({tdm_lines_high, tdm_clocks_keep}, 2'h3);
      @(posedge aclk) ext_reset_in_n <= 1'b1;
      wait_ok;
      rdc(8'h0C, 8'h00, OK);
      rdc(8'h10, 8'h00, OK);
   endtask
   task automatic t_por;
      wr(8'h00, 8'h01, OK);
      @(posedge aclk) undervoltage_detect <= 1'b1;
      repeat (30) @(negedge aclk);
      chk(device_reset, 1'b0);
      @(posedge aclk) supply_detect_en_n <= 1'b0;
      repeat (30) @(negedge aclk);
      chk({device_reset, reset_out_n, reset_out_oe}, 3'h5);
      @(posedge aclk) undervoltage_detect <= 1'b0;
      wait_lvl(1'b1, 100, n);
      chk(n >= DEACT, 1'b1);
      @(posedge aclk) supply_detect_en_n <= 1'b1;
      wait_ok;
   endtask
   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, fs_run} = 3'h0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      {ext_reset_in_n, supply_detect_en_n, tdm_clocks_active} = 3'h7;
      undervoltage_detect = 1'b0;
      line_cmd_code_dn = 4'h3;
      bad_count = 0;
      checked = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      wait_ok;
      t_regs;
      t_sel;
      t_ci;
      t_wd;
      t_ext;
      t_por;
      end_sim;
   end
endmodule
bind rsw_reset_watchdog rsw_chk #(.PULSE_CYC(PULSE_CYC)) u_chk (
   .aclk, .aresetn, .ext_reset_in_n, .supply_detect_en_n,
   .undervoltage_detect, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
   .reset_out_n, .device_reset, .block_reset, .tdm_lines_high,
   .ci_dn_reset_code, .ci_up_reset_code, .tdm_clocks_keep);
